// *** timer_pkg.sv ***
// Overview of operation
// - Any count write blocks compare matches at the next timer tick.
// - Writing a count equal to a compare value loses that match.
// - Capture enable, width and clear-on-match bits choose the mode.
// - Normal 8-bit mode: low byte increments per tick and wraps to zero.
// - Normal 8-bit mode: overflow flag sets as low byte becomes zero.
// - Overflow flag clears when the overflow interrupt is executed.
// - Clear-on-match mode: counter clears after equalling compare A.
// - Compare A acts at once; below count, counter wraps before matching.
// - Clear-on-match mode: compare A flag sets each time top is reached.
// - Clear-on-match mode: overflow flag sets on maximum to zero.
// - Normal 16-bit mode: count wraps at 16-bit maximum, overflow sets.
// - 8-bit capture mode: free-running 8-bit count, overflow at maximum.
// - 16-bit capture mode: free-running 16-bit count, overflow at top.
// - Wide mode: 16-bit registers share one temporary high-byte register.
// - Low byte write loads temporary high and written low together.
// - Low byte read copies the register high byte into temporary.
// - Compare pair reads bypass temporary; 16-bit capture reads use it.
// - Processor count write beats any clear or increment that cycle.
// - Match sets its flag at next tick; normal 16-bit mode only flag A, 16-bit capture mode neither.
package timer_pkg;

   // -----------------------------------------------------------------
   // Byte register selects
   // -----------------------------------------------------------------
   localparam logic [1:0] SEL_CNT_LO = 2'h0;
   localparam logic [1:0] SEL_CNT_HI = 2'h1;
   localparam logic [1:0] SEL_CMP_A  = 2'h2;
   localparam logic [1:0] SEL_CMP_B  = 2'h3;

   // -----------------------------------------------------------------
   // Counter limits and reset values
   // -----------------------------------------------------------------
   localparam logic [7:0]  MAX_8     = 8'hff;
   localparam logic [15:0] MAX_16    = 16'hffff;
   localparam logic [7:0]  BOTTOM_8  = 8'h00;
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [7:0]  INC_8     = 8'h01;
   localparam logic [15:0] INC_16    = 16'h0001;

   // -----------------------------------------------------------------
   // Operating modes
   // -----------------------------------------------------------------
   typedef enum logic [4:0] {
      MODE_N8    = 5'b00001,
      MODE_CTC8  = 5'b00010,
      MODE_N16   = 5'b00100,
      MODE_CAP8  = 5'b01000,
      MODE_CAP16 = 5'b10000
   } mode_t;

endpackage

// *** compare_flag.sv ***
`timescale 1ns/100ps
module compare_flag (
   input  wire logic clock,   // System clock
   input  wire logic arst_n,  // Async reset, active low
   input  wire logic tick,    // Timer tick enable
   input  wire logic match,   // Count equals compare value
   input  wire logic enable,  // Unit usable in this mode
   input  wire logic block,   // Match suppressed this tick
   input  wire logic ack,     // Flag clear request
   output logic      flag     // Sticky compare flag
);

   logic setEvent;

   // -----------------------------------------------------------------
   // Flag set and clear
   // -----------------------------------------------------------------
   assign setEvent = tick && match && enable && !block;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         flag <= 1'b0;
      end else if (setEvent) begin
         flag <= 1'b1;
      end else if (ack) begin
         flag <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   AST_MATCH_SETS: assert property (
      @(posedge clock) disable iff (!arst_n)
      tick && match && enable && !block |=> flag)
      else $error("Compare match did not set flag");

   AST_BLOCKED_NO_SET: assert property (
      @(posedge clock) disable iff (!arst_n)
      !flag && block && !(tick && match && enable && !block) |=> !flag)
      else $error("Blocked match set the flag");

   AST_SET_WINS: assert property (
      @(posedge clock) disable iff (!arst_n)
      setEvent && ack |=> flag)
      else $error("Clear beat a simultaneous set");

endmodule

// *** timer_core.sv ***
`timescale 1ns/100ps
module timer_core (
   input  wire logic       clock,              // System clock, 50 MHz
   input  wire logic       arst_n,             // Async reset, active low
   input  wire logic       timerTick,          // Timer clock enable pulse
   input  wire logic       captureEnable,      // Capture mode select
   input  wire logic       widthSelect,        // 16-bit width select
   input  wire logic       clearOnMatchSelect, // Clear-on-match select
   input  wire logic       captureEvent,       // Capture trigger pulse
   input  wire logic [1:0] regSel,             // Byte register select
   input  wire logic       regWrite,           // Byte write strobe
   input  wire logic       regRead,            // Byte read strobe
   input  wire logic [7:0] regWrData,          // Byte write data
   output logic      [7:0] regRdData,          // Byte read data
   input  wire logic       overflowAck,        // Overflow interrupt taken
   input  wire logic       compareAAck,        // Compare A interrupt taken
   input  wire logic       compareBAck,        // Compare B interrupt taken
   output logic            overflowFlag,       // Overflow flag
   output logic            compareAFlag,       // Compare A flag
   output logic            compareBFlag,       // Compare B flag
   output logic     [15:0] timerCount          // Count pair value
);

   // -----------------------------------------------------------------
   // Mode decode
   // -----------------------------------------------------------------
   function automatic timer_pkg::mode_t decodeMode(
      input logic capEn,
      input logic wide,
      input logic clrOnMatch
   );
      timer_pkg::mode_t m;
      m = timer_pkg::MODE_N8;
      if (capEn) begin
         m = wide ? timer_pkg::MODE_CAP16 : timer_pkg::MODE_CAP8;
      end else if (wide) begin
         m = timer_pkg::MODE_N16;
      end else if (clrOnMatch) begin
         m = timer_pkg::MODE_CTC8;
      end
      return m;
   endfunction

   timer_pkg::mode_t mode;
   logic             wide;
   logic             capMode;

   assign mode    = decodeMode(captureEnable, widthSelect,
                               clearOnMatchSelect);
   assign wide    = widthSelect;
   assign capMode = (mode == timer_pkg::MODE_CAP8) ||
                    (mode == timer_pkg::MODE_CAP16);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [15:0] countPair_r;
   logic [7:0]  compareRegA_r;
   logic [7:0]  compareRegB_r;
   logic [7:0]  tempHigh_r;
   logic [7:0]  rdData_r;
   logic        blockPending_r;
   logic        overflow_r;

   logic [7:0]  countLowByte;
   logic [7:0]  countHighByte;
   logic [15:0] comparePair;

   assign countLowByte  = countPair_r[7:0];
   assign countHighByte = countPair_r[15:8];
   assign comparePair   = {compareRegB_r, compareRegA_r};

   // -----------------------------------------------------------------
   // Access decode
   // -----------------------------------------------------------------
   logic wrCntLo;
   logic wrCntHi;
   logic wrCmpA;
   logic wrCmpB;
   logic rdCntLo;
   logic rdCmpA;
   logic countWrite;
   logic countUpdate;

   assign wrCntLo     = regWrite && (regSel == timer_pkg::SEL_CNT_LO);
   assign wrCntHi     = regWrite && (regSel == timer_pkg::SEL_CNT_HI);
   assign wrCmpA      = regWrite && (regSel == timer_pkg::SEL_CMP_A);
   assign wrCmpB      = regWrite && (regSel == timer_pkg::SEL_CMP_B);
   assign rdCntLo     = regRead && (regSel == timer_pkg::SEL_CNT_LO);
   assign rdCmpA      = regRead && (regSel == timer_pkg::SEL_CMP_A);
   assign countWrite  = wrCntLo || wrCntHi;
   assign countUpdate = wrCntLo || (wrCntHi && !wide);

   // -----------------------------------------------------------------
   // Counter
   // -----------------------------------------------------------------
   logic ctcClear;
   logic atMax;

   assign ctcClear = (mode == timer_pkg::MODE_CTC8) &&
                     (countLowByte == compareRegA_r);
   assign atMax    = wide ? (countPair_r == timer_pkg::MAX_16)
                          : (countLowByte == timer_pkg::MAX_8);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         countPair_r <= timer_pkg::RST_WORD;
      end else if (wrCntLo) begin
         if (wide) begin
            countPair_r <= {tempHigh_r, regWrData};
         end else begin
            countPair_r[7:0] <= regWrData;
         end
      end else if (wrCntHi && !wide) begin
         countPair_r[15:8] <= regWrData;
      end else if (timerTick) begin
         if (wide) begin
            countPair_r <= countPair_r + timer_pkg::INC_16;
         end else if (ctcClear) begin
            countPair_r[7:0] <= timer_pkg::BOTTOM_8;
         end else begin
            countPair_r[7:0] <= countLowByte + timer_pkg::INC_8;
         end
      end
   end

   // -----------------------------------------------------------------
   // Overflow flag
   // -----------------------------------------------------------------
   logic overflowEvent;

   assign overflowEvent = timerTick && !countUpdate && atMax;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         overflow_r <= 1'b0;
      end else if (overflowEvent) begin
         overflow_r <= 1'b1;
      end else if (overflowAck) begin
         overflow_r <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Compare blocking after a count write
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         blockPending_r <= 1'b0;
      end else if (countWrite) begin
         blockPending_r <= 1'b1;
      end else if (timerTick) begin
         blockPending_r <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Compare registers and capture
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         compareRegA_r <= timer_pkg::RST_BYTE;
         compareRegB_r <= timer_pkg::RST_BYTE;
      end else if (wrCmpA) begin
         compareRegA_r <= regWrData;
         if (wide) begin
            compareRegB_r <= tempHigh_r;
         end
      end else if (wrCmpB && !wide) begin
         compareRegB_r <= regWrData;
      end else if (captureEvent && capMode) begin
         compareRegA_r <= countLowByte;
         if (mode == timer_pkg::MODE_CAP16) begin
            compareRegB_r <= countHighByte;
         end
      end
   end

   // -----------------------------------------------------------------
   // Temporary high byte
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tempHigh_r <= timer_pkg::RST_BYTE;
      end else if (wide && (wrCntHi || wrCmpB)) begin
         tempHigh_r <= regWrData;
      end else if (wide && rdCntLo) begin
         tempHigh_r <= countHighByte;
      end else if (rdCmpA && mode == timer_pkg::MODE_CAP16) begin
         tempHigh_r <= compareRegB_r;
      end
   end

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   logic [7:0] rdMux;

   always_comb begin
      case (regSel)
         timer_pkg::SEL_CNT_LO: rdMux = countLowByte;
         timer_pkg::SEL_CNT_HI: rdMux = wide ? tempHigh_r : countHighByte;
         timer_pkg::SEL_CMP_A:  rdMux = compareRegA_r;
         timer_pkg::SEL_CMP_B: begin
            if (mode == timer_pkg::MODE_CAP16) begin
               rdMux = tempHigh_r;
            end else begin
               rdMux = compareRegB_r;
            end
         end
         default: rdMux = timer_pkg::RST_BYTE;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdData_r <= timer_pkg::RST_BYTE;
      end else if (regRead) begin
         rdData_r <= rdMux;
      end
   end

   // -----------------------------------------------------------------
   // Compare units
   // -----------------------------------------------------------------
   logic [1:0] cmpMatch;
   logic [1:0] cmpEnable;
   logic [1:0] cmpAck;
   logic [1:0] cmpFlag;
   logic       cmpBlock;

   assign cmpMatch[0]  = wide ? (countPair_r == comparePair)
                              : (countLowByte == compareRegA_r);
   assign cmpMatch[1]  = countLowByte == compareRegB_r;
   assign cmpEnable[0] = (mode == timer_pkg::MODE_N8) ||
                         (mode == timer_pkg::MODE_CTC8) ||
                         (mode == timer_pkg::MODE_N16);
   assign cmpEnable[1] = (mode == timer_pkg::MODE_N8) ||
                         (mode == timer_pkg::MODE_CTC8) ||
                         (mode == timer_pkg::MODE_CAP8);
   assign cmpBlock     = blockPending_r || countWrite;
   assign cmpAck       = {compareBAck, compareAAck};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : gCmp
         compare_flag uFlag (
            .clock  (clock),
            .arst_n (arst_n),
            .tick   (timerTick),
            .match  (cmpMatch[gi]),
            .enable (cmpEnable[gi]),
            .block  (cmpBlock),
            .ack    (cmpAck[gi]),
            .flag   (cmpFlag[gi])
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign regRdData    = rdData_r;
   assign overflowFlag = overflow_r;
   assign compareAFlag = cmpFlag[0];
   assign compareBFlag = cmpFlag[1];
   assign timerCount   = countPair_r;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence wideHighThenLow;
      (wide && wrCntHi) ##1 (wide && wrCntLo);
   endsequence

   sequence countWriteThenTick;
      countWrite ##1 (timerTick && !countWrite);
   endsequence

   AST_WIDE_WRITE: assert property (
      @(posedge clock) disable iff (!arst_n)
      wideHighThenLow |=>
         countPair_r == {$past(regWrData, 2), $past(regWrData)})
      else $error("Wide count write did not load both bytes");

   AST_WRITE_PRIORITY: assert property (
      @(posedge clock) disable iff (!arst_n)
      wrCntLo && !wide |=> countLowByte == $past(regWrData))
      else $error("Count write lost to count or clear");

   AST_HOLD: assert property (
      @(posedge clock) disable iff (!arst_n)
      !timerTick && !countUpdate |=> $stable(countPair_r))
      else $error("Count moved without a tick");

   AST_WRAP_8: assert property (
      @(posedge clock) disable iff (!arst_n)
      timerTick && !countUpdate && mode == timer_pkg::MODE_N8 &&
      countLowByte == timer_pkg::MAX_8 |=>
         countLowByte == timer_pkg::BOTTOM_8 && overflow_r)
      else $error("8-bit wrap or overflow wrong");

   AST_CTC_CLEAR: assert property (
      @(posedge clock) disable iff (!arst_n)
      timerTick && !countUpdate && ctcClear |=>
         countLowByte == timer_pkg::BOTTOM_8)
      else $error("Clear-on-match did not clear count");

   AST_WRAP_16: assert property (
      @(posedge clock) disable iff (!arst_n)
      timerTick && !countUpdate && wide &&
      countPair_r == timer_pkg::MAX_16 |=>
         countPair_r == timer_pkg::RST_WORD && overflow_r)
      else $error("16-bit wrap or overflow wrong");

   AST_OVF_STICKY: assert property (
      @(posedge clock) disable iff (!arst_n)
      overflow_r && !overflowAck |=> overflow_r)
      else $error("Overflow flag dropped without acknowledge");

   AST_BLOCK_NEXT_TICK: assert property (
      @(posedge clock) disable iff (!arst_n)
      countWriteThenTick and (##1 !compareAFlag && !compareAAck)
         |=> !compareAFlag)
      else $error("Match set flag right after count write");

   AST_TEMP_READ: assert property (
      @(posedge clock) disable iff (!arst_n)
      wide && rdCntLo |=> tempHigh_r == $past(countHighByte))
      else $error("Low read did not latch high byte");

   AST_WIDE_ONLY_A: assert property (
      @(posedge clock) disable iff (!arst_n)
      wide && !compareBFlag ##1 wide |-> !compareBFlag)
      else $error("Compare B flag set in wide mode");

   AST_OVF_CLEAR: assert property (
      @(posedge clock) disable iff (!arst_n)
      overflowAck && !overflowEvent |=> !overflow_r)
      else $error("Overflow acknowledge did not clear flag");

   AST_CMP_READ_DIRECT: assert property (
      @(posedge clock) disable iff (!arst_n)
      regRead && regSel == timer_pkg::SEL_CMP_B &&
      mode == timer_pkg::MODE_N16 |=> regRdData == $past(compareRegB_r))
      else $error("Compare pair read went through temporary byte");

endmodule

// *** cpu_model.sv ***
`timescale 1ns/100ps
module cpu_model (
   input  wire logic       clock,     // System clock
   output logic      [1:0] regSel,    // Byte select
   output logic            regWrite,  // Write strobe
   output logic            regRead,   // Read strobe
   output logic      [7:0] regWrData  // Write data
);
   logic [7:0] expQ [$];

   initial begin
      regSel    = 2'h0;
      regWrite  = 1'b0;
      regRead   = 1'b0;
      regWrData = 8'h00;
   end

   // ------------------------------------------------------------
   // Byte accesses, one idle cycle after each except the high byte of wr16
   // ------------------------------------------------------------
   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      regSel    <= s;
      regWrData <= d;
      regWrite  <= 1'b1;
      @(posedge clock);
      regWrite  <= 1'b0;
      regWrData <= ~d;
      @(posedge clock);
   endtask

   task automatic rd(input logic [1:0] s, input logic [7:0] e);
      expQ.push_back(e);
      regSel  <= s;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr16(input logic [1:0] s, input logic [15:0] v);
      regSel    <= s + 2'h1;
      regWrData <= v[15:8];
      regWrite  <= 1'b1;
      @(posedge clock);
      wr(s, v[7:0]);
   endtask

   task automatic rd16(input logic [1:0] s, input logic [15:0] e);
      rd(s, e[7:0]);
      rd(s + 2'h1, e[15:8]);
   endtask
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
   logic        clock;
   logic        arst_n;
   logic        timerTick;
   logic        captureEnable;
   logic        widthSelect;
   logic        clearOnMatchSelect;
   logic        captureEvent;
   logic        overflowAck;
   logic        compareAAck;
   logic        compareBAck;
   logic [1:0]  regSel;
   logic        regWrite;
   logic        regRead;
   logic [7:0]  regWrData;
   logic [7:0]  regRdData;
   logic        overflowFlag;
   logic        compareAFlag;
   logic        compareBFlag;
   logic [15:0] timerCount;
   logic        rdPend;
   logic        wide;
   logic [31:0] seed;
   logic [15:0] rv;
   logic [7:0]  ctcSeq [6];
   int          err_total;
   int          n_checks;
   int          cycles;

   cpu_model cpu_u (.clock(clock), .regSel(regSel), .regWrite(regWrite),
      .regRead(regRead), .regWrData(regWrData));

   timer_core dut_u (.clock(clock), .arst_n(arst_n), .timerTick(timerTick),
      .captureEnable(captureEnable), .widthSelect(widthSelect),
      .clearOnMatchSelect(clearOnMatchSelect), .captureEvent(captureEvent),
      .regSel(regSel), .regWrite(regWrite), .regRead(regRead),
      .regWrData(regWrData), .regRdData(regRdData),
      .overflowAck(overflowAck), .compareAAck(compareAAck),
      .compareBAck(compareBAck), .overflowFlag(overflowFlag),
      .compareAFlag(compareAFlag), .compareBFlag(compareBFlag),
      .timerCount(timerCount));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic flags(input logic [2:0] e);
      check("flags", {13'h0000, overflowFlag, compareAFlag, compareBFlag},
            {13'h0000, e});
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Read data lands one cycle after the strobe edge
   always @(posedge clock) begin
      if (rdPend) begin
         check("read data", {8'h00, regRdData},
               {8'h00, cpu_u.expQ.pop_front()});
      end
      rdPend <= regRead;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // Stimulus helpers
   // ------------------------------------------------------------
   task automatic pulse(input logic t, input logic o, input logic a,
                        input logic b);
      timerTick   <= t;
      overflowAck <= o;
      compareAAck <= a;
      compareBAck <= b;
      @(posedge clock);
      timerTick   <= 1'b0;
      overflowAck <= 1'b0;
      compareAAck <= 1'b0;
      compareBAck <= 1'b0;
      @(posedge clock);
   endtask

   task automatic setMode(input logic c, input logic w, input logic m);
      captureEnable      <= c;
      widthSelect        <= w;
      clearOnMatchSelect <= m;
      @(posedge clock);
   endtask

   initial begin
      arst_n = 1'b0;
      timerTick = 1'b0;
      captureEnable = 1'b0;
      widthSelect = 1'b0;
      clearOnMatchSelect = 1'b0;
      captureEvent = 1'b0;
      overflowAck = 1'b0;
      compareAAck = 1'b0;
      compareBAck = 1'b0;
      rdPend = 1'b0;
      wide = 1'b0;
      seed = 32'h9ea506c0;
      err_total = 0;
      n_checks = 0;
      cycles = 0;
      ctcSeq = '{8'hfe, 8'hff, 8'h00, 8'h01, 8'h02, 8'h00};
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      check("count", timerCount, 16'h0000);
      flags(3'b000);
      rv = 16'($random(seed));
      cpu_u.wr(timer_pkg::SEL_CNT_LO, rv[7:0]);
      repeat (3) @(posedge clock);
      check("count", {8'h00, timerCount[7:0]}, {8'h00, rv[7:0]});
      cpu_u.rd(timer_pkg::SEL_CNT_LO, rv[7:0]);
      // Overflow at the top of every mode
      cpu_u.wr(timer_pkg::SEL_CMP_A, 8'h00);
      cpu_u.wr(timer_pkg::SEL_CMP_B, 8'h00);
      for (int m = 0; m < 5; m++) begin
         setMode(m >= 3, (m == 2) || (m == 4), (m == 1) || (m == 4));
         wide = (m == 2) || (m == 4);
         if (wide) begin
            cpu_u.wr16(timer_pkg::SEL_CNT_LO, 16'hffff);
         end else begin
            cpu_u.wr(timer_pkg::SEL_CNT_LO, 8'hff);
         end
         pulse(1'b1, 1'b0, 1'b0, 1'b0);
         check("count", wide ? timerCount : {8'h00, timerCount[7:0]},
               16'h0000);
         flags(3'b100);
         pulse(1'b0, 1'b1, 1'b0, 1'b0);
         flags(3'b000);
      end
      // Match blocking after count writes
      setMode(1'b0, 1'b0, 1'b0);
      cpu_u.wr(timer_pkg::SEL_CMP_A, 8'h06);
      cpu_u.wr(timer_pkg::SEL_CMP_B, 8'h05);
      cpu_u.wr(timer_pkg::SEL_CNT_LO, 8'h05);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      flags(3'b000);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      flags(3'b010);
      pulse(1'b0, 1'b0, 1'b1, 1'b0);
      cpu_u.wr(timer_pkg::SEL_CMP_B, 8'h07);
      cpu_u.wr(timer_pkg::SEL_CNT_HI, 8'h00);
      repeat (5) @(posedge clock);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      check("count", {8'h00, timerCount[7:0]}, 16'h0008);
      flags(3'b000);
      cpu_u.wr(timer_pkg::SEL_CMP_B, 8'h08);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      flags(3'b001);
      pulse(1'b0, 1'b0, 1'b0, 1'b1);
      // Count write and tick in the same cycle
      timerTick <= 1'b1;
      cpu_u.wr(timer_pkg::SEL_CNT_LO, 8'h40);
      timerTick <= 1'b0;
      @(posedge clock);
      check("count", {8'h00, timerCount[7:0]}, 16'h0041);
      // Clear on match with top below the count
      setMode(1'b0, 1'b0, 1'b1);
      cpu_u.wr(timer_pkg::SEL_CMP_A, 8'h02);
      cpu_u.wr(timer_pkg::SEL_CNT_LO, 8'hfd);
      for (int i = 0; i < 6; i++) begin
         pulse(1'b1, 1'b0, 1'b0, 1'b0);
         check("count", {8'h00, timerCount[7:0]},
               {8'h00, ctcSeq[i]});
         if (i == 2) begin
            flags(3'b100);
         end
      end
      flags(3'b110);
      pulse(1'b0, 1'b1, 1'b1, 1'b1);
      // Wide access through the shared high byte
      setMode(1'b0, 1'b1, 1'b0);
      cpu_u.wr16(timer_pkg::SEL_CMP_A, 16'h1300);
      cpu_u.wr16(timer_pkg::SEL_CNT_LO, 16'h12ff);
      check("count", timerCount, 16'h12ff);
      cpu_u.rd(timer_pkg::SEL_CNT_LO, 8'hff);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      cpu_u.rd(timer_pkg::SEL_CNT_HI, 8'h12);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      check("count", timerCount, 16'h1301);
      flags(3'b010);
      cpu_u.rd(timer_pkg::SEL_CMP_A, 8'h00);
      cpu_u.rd(timer_pkg::SEL_CMP_B, 8'h13);
      pulse(1'b0, 1'b0, 1'b1, 1'b0);
      // Wide capture read through the shared high byte
      setMode(1'b1, 1'b1, 1'b0);
      rv = 16'($random(seed));
      cpu_u.wr16(timer_pkg::SEL_CNT_LO, rv);
      cpu_u.wr(timer_pkg::SEL_CNT_HI, ~rv[15:8]);
      captureEvent <= 1'b1;
      @(posedge clock);
      captureEvent <= 1'b0;
      @(posedge clock);
      cpu_u.rd16(timer_pkg::SEL_CMP_A, rv);
      repeat (2) @(posedge clock);
      conclude();
   end
endmodule
